/* rtl/bmcs_consts.svh */
// Offsets, field positions and reset values of the compare-swap register group
`ifndef BMCS_CONSTS_SVH
`define BMCS_CONSTS_SVH

`define BMCS_ADDR_W        8
`define BMCS_OFF_NEW_VALUE 8'h0C
`define BMCS_OFF_CMP_VALUE 8'h10
`define BMCS_OFF_CONTROL   8'h14
`define BMCS_OFF_IRQ_STAT  8'h20
`define BMCS_OFF_IRQ_MASK  8'h24

`define BMCS_DONE_BIT      31
`define BMCS_SEL_LSB       0
`define BMCS_SEL_MSB       1
`define BMCS_EVT_DONE_BIT  0
`define BMCS_EVT_FAIL_BIT  1
`define BMCS_EVT_W         2

`define BMCS_RST_CONTROL   32'h8000_0000
`define BMCS_RST_WORD      32'h0000_0000
`define BMCS_RST_EVT       2'h0
`define BMCS_RST_BUS_MGR   32'h0000_0000
`define BMCS_RST_BANDWIDTH 32'h0000_0000
`define BMCS_RST_CHAN_HI   32'h0000_0000
`define BMCS_RST_CHAN_LO   32'h0000_0000

`endif

/* rtl/bmcs_pkg.sv */
// Types shared by the compare-swap register group
package bmcs_pkg;
  typedef logic [31:0] bmcs_word_t;
  typedef enum logic [1:0] {
    BMCS_SEL_BUS_MGR   = 2'h0,
    BMCS_SEL_BANDWIDTH = 2'h1,
    BMCS_SEL_CHAN_HI   = 2'h2,
    BMCS_SEL_CHAN_LO   = 2'h3
  } bmcs_sel_t;
endpackage

/* rtl/bmcs_swap_if.sv */
// Request and result signals between register front end and resource bank
`timescale 1ns/10ps
interface bmcs_swap_if;
  import bmcs_pkg::*;
  logic       start;
  bmcs_sel_t  sel;
  bmcs_word_t cmpVal;
  bmcs_word_t newVal;
  logic       done;
  logic       success;
  bmcs_word_t oldVal;
  bmcs_word_t res [4];
  modport ctl  (output start, sel, cmpVal, newVal, input done, success, oldVal, res);
  modport bank (input start, sel, cmpVal, newVal, output done, success, oldVal, res);
endinterface

/* rtl/bmcs_resource_bank.sv */
// Four bus management resources with single-cycle compare-swap
`timescale 1ns/10ps
`include "bmcs_consts.svh"
module bmcs_resource_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstN,
  // Swap request
  bmcs_swap_if.bank swapIf
);
  import bmcs_pkg::*;

  localparam bmcs_word_t RES_INIT [4] = '{`BMCS_RST_BUS_MGR, `BMCS_RST_BANDWIDTH,
                                          `BMCS_RST_CHAN_HI, `BMCS_RST_CHAN_LO};

  bmcs_word_t resQ [4];
  wire        match;

  // Whole-word compare, no partial match
  assign swapIf.oldVal  = resQ[swapIf.sel];
  assign match          = (swapIf.oldVal == swapIf.cmpVal);
  assign swapIf.done    = swapIf.start;
  assign swapIf.success = swapIf.start & match;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_res
      wire hitThis;
      assign hitThis = swapIf.success & (swapIf.sel == bmcs_sel_t'(i));
      always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
          resQ[i] <= RES_INIT[i];
        end else if (hitThis) begin
          resQ[i] <= swapIf.newVal;
        end
      end
      assign swapIf.res[i] = resQ[i];

      property p_other_stable;
        @(posedge clk_sys) disable iff (!rstN)
        swapIf.start && swapIf.sel != bmcs_sel_t'(i) |=> $stable(resQ[i]);
      endproperty
      a_other_stable: assert property (p_other_stable)
        else $error("Unselected resource changed");
    end
  endgenerate

  property p_swap_store;
    @(posedge clk_sys) disable iff (!rstN)
    swapIf.start && match |=> swapIf.res[$past(swapIf.sel)] == $past(swapIf.newVal);
  endproperty
  a_swap_store: assert property (p_swap_store)
    else $error("Matching swap did not store new value");

  property p_swap_keep;
    @(posedge clk_sys) disable iff (!rstN)
    swapIf.start && !match |=> swapIf.res[$past(swapIf.sel)] == $past(swapIf.oldVal);
  endproperty
  a_swap_keep: assert property (p_swap_keep)
    else $error("Failed compare altered resource");

  property p_compare;
    @(posedge clk_sys) disable iff (!rstN)
    swapIf.done |-> swapIf.success == (swapIf.cmpVal == swapIf.res[swapIf.sel]);
  endproperty
  a_compare: assert property (p_compare)
    else $error("Swap outcome disagrees with compare value");
endmodule // bmcs_resource_bank

/* rtl/bmcs_regs.sv */
// APB register front end for compare-swap on bus management resources
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "bmcs_consts.svh"
module bmcs_regs (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  // APB slave
  input  wire logic [`BMCS_ADDR_W-1:0]     paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Interrupt
  output      logic                        irq,
  // Resource values
  output      bmcs_pkg::bmcs_word_t        busManagerId,
  output      bmcs_pkg::bmcs_word_t        bandwidthAvail,
  output      bmcs_pkg::bmcs_word_t        channelsAvailHi,
  output      bmcs_pkg::bmcs_word_t        channelsAvailLo
);
  import bmcs_pkg::*;

  // Reset release synchroniser
  logic [1:0] rstSyncQ;
  wire        rstN;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstSyncQ <= 2'h0;
    end else begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  // Bus phase and address decode
  wire setupPh;
  wire accessPh;
  wire hitNew;
  wire hitCmp;
  wire hitCtrl;
  wire hitSts;
  wire hitMask;
  wire addrHit;
  wire wrNew;
  wire wrCmp;
  wire wrCtrl;
  wire wrSts;
  wire wrMask;

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign hitNew   = (paddr == `BMCS_OFF_NEW_VALUE);
  assign hitCmp   = (paddr == `BMCS_OFF_CMP_VALUE);
  assign hitCtrl  = (paddr == `BMCS_OFF_CONTROL);
  assign hitSts   = (paddr == `BMCS_OFF_IRQ_STAT);
  assign hitMask  = (paddr == `BMCS_OFF_IRQ_MASK);
  assign addrHit  = hitNew | hitCmp | hitCtrl | hitSts | hitMask;
  assign wrNew    = accessPh & pwrite & hitNew;
  assign wrCmp    = accessPh & pwrite & hitCmp;
  assign wrCtrl   = accessPh & pwrite & hitCtrl;
  assign wrSts    = accessPh & pwrite & hitSts;
  assign wrMask   = accessPh & pwrite & hitMask;

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = accessPh;
  assign pslverr = accessPh & ~addrHit;

  // Register state
  bmcs_word_t               newValQ;
  bmcs_word_t               cmpValQ;
  bmcs_sel_t                selQ;
  logic                     startQ;
  logic                     doneFlagQ;
  logic                     doneFlagD;
  logic [`BMCS_EVT_W-1:0]   evtStsQ;
  logic [`BMCS_EVT_W-1:0]   evtStsD;
  logic [`BMCS_EVT_W-1:0]   evtMaskQ;
  logic [`BMCS_EVT_W-1:0]   evtSet;
  logic [31:0]              prdataQ;

  bmcs_swap_if swapIf ();

  // Operand registers, written by software before starting a swap
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      newValQ <= `BMCS_RST_WORD;
      cmpValQ <= `BMCS_RST_WORD;
    end else begin
      if (wrNew) begin
        newValQ <= pwdata;
      end
      if (wrCmp) begin
        cmpValQ <= pwdata;
      end
    end
  end

  // Control write selects and launches a swap one cycle later
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      selQ   <= BMCS_SEL_BUS_MGR;
      startQ <= 1'b0;
    end else begin
      startQ <= wrCtrl;
      if (wrCtrl) begin
        selQ <= bmcs_sel_t'(pwdata[`BMCS_SEL_MSB:`BMCS_SEL_LSB]);
      end
    end
  end

  // Completion wins over a control write in the same cycle
  assign doneFlagD = swapIf.done ? 1'b1 : (wrCtrl ? 1'b0 : doneFlagQ);

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      doneFlagQ <= 1'(`BMCS_RST_CONTROL >> `BMCS_DONE_BIT);
    end else begin
      doneFlagQ <= doneFlagD;
    end
  end

  // Sticky events, write one to clear, set beats clear
  always_comb begin
    evtSet                     = '0;
    evtSet[`BMCS_EVT_DONE_BIT] = swapIf.done;
    evtSet[`BMCS_EVT_FAIL_BIT] = swapIf.done & ~swapIf.success;
    evtStsD                    = evtSet | (evtStsQ & ~(wrSts ? pwdata[`BMCS_EVT_W-1:0] : '0));
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      evtStsQ  <= `BMCS_RST_EVT;
      evtMaskQ <= `BMCS_RST_EVT;
    end else begin
      evtStsQ <= evtStsD;
      if (wrMask) begin
        evtMaskQ <= pwdata[`BMCS_EVT_W-1:0];
      end
    end
  end

  assign irq = |(evtStsQ & evtMaskQ);

  // Read path
  wire [31:0] ctrlRead;
  wire [31:0] rdMux;

  assign ctrlRead = {doneFlagQ, 29'h0000_0000, selQ};
  assign rdMux    = hitNew  ? newValQ :
                    hitCmp  ? cmpValQ :
                    hitCtrl ? ctrlRead :
                    hitSts  ? {30'h0000_0000, evtStsQ} :
                    hitMask ? {30'h0000_0000, evtMaskQ} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      prdataQ <= 32'h0000_0000;
    end else if (setupPh) begin
      prdataQ <= rdMux;
    end
  end
  assign prdata = prdataQ;

  // Resource bank
  assign swapIf.start  = startQ;
  assign swapIf.sel    = selQ;
  assign swapIf.cmpVal = cmpValQ;
  assign swapIf.newVal = newValQ;

  bmcs_resource_bank bmcs_resource_bank_inst (
    .clk_sys (clk_sys),
    .rstN    (rstN),
    .swapIf  (swapIf)
  );

  assign busManagerId    = swapIf.res[0];
  assign bandwidthAvail  = swapIf.res[1];
  assign channelsAvailHi = swapIf.res[2];
  assign channelsAvailLo = swapIf.res[3];

  // Checks
  sequence s_ctrl_write;
    wrCtrl;
  endsequence

  sequence s_swap_runs;
    ##1 startQ && swapIf.done;
  endsequence

  sequence s_flag_up;
    ##1 doneFlagQ;
  endsequence

  property p_done_after_write;
    @(posedge clk_sys) disable iff (!rstN)
    s_ctrl_write |-> s_swap_runs ##0 s_flag_up;
  endproperty
  a_done_after_write: assert property (p_done_after_write)
    else $error("Completion flag not set two cycles after control write");

  property p_flag_cleared;
    @(posedge clk_sys) disable iff (!rstN)
    wrCtrl && !swapIf.done |=> !doneFlagQ;
  endproperty
  a_flag_cleared: assert property (p_flag_cleared)
    else $error("Control write did not clear completion flag");

  property p_flag_holds;
    @(posedge clk_sys) disable iff (!rstN)
    !wrCtrl && !swapIf.done |=> doneFlagQ == $past(doneFlagQ);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("Completion flag changed without cause");

  property p_start_uses_sel;
    @(posedge clk_sys) disable iff (!rstN)
    wrCtrl |=> startQ && swapIf.sel == bmcs_sel_t'($past(pwdata[1:0]));
  endproperty
  a_start_uses_sel: assert property (p_start_uses_sel)
    else $error("Swap not started on written select");

  property p_no_spurious_start;
    @(posedge clk_sys) disable iff (!rstN)
    !wrCtrl |=> !startQ;
  endproperty
  a_no_spurious_start: assert property (p_no_spurious_start)
    else $error("Swap started without control write");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rstN)
    accessPh && !pwrite && hitCtrl |-> prdata[30:2] == 29'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bits read nonzero");

  property p_ctrl_read_flag;
    @(posedge clk_sys) disable iff (!rstN)
    setupPh && !pwrite && hitCtrl ##1 accessPh |-> prdata[31] == $past(doneFlagQ);
  endproperty
  a_ctrl_read_flag: assert property (p_ctrl_read_flag)
    else $error("Control read does not show completion flag");

  property p_irq_level;
    @(posedge clk_sys) disable iff (!rstN)
    swapIf.done && evtMaskQ[`BMCS_EVT_DONE_BIT] |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked completion did not raise interrupt");

  // Operands move only on their own writes, so a swap uses what software left
  property p_new_value_write;
    @(posedge clk_sys) disable iff (!rstN)
    wrNew |=> newValQ == $past(pwdata);
  endproperty
  a_new_value_write: assert property (p_new_value_write)
    else $error("New value register missed a write");

  property p_cmp_value_write;
    @(posedge clk_sys) disable iff (!rstN)
    wrCmp |=> cmpValQ == $past(pwdata);
  endproperty
  a_cmp_value_write: assert property (p_cmp_value_write)
    else $error("Compare value register missed a write");

  property p_operands_hold;
    @(posedge clk_sys) disable iff (!rstN)
    !wrNew && !wrCmp |=> $stable(newValQ) && $stable(cmpValQ);
  endproperty
  a_operands_hold: assert property (p_operands_hold)
    else $error("Operand register changed without a write");

  property p_sel_hold;
    @(posedge clk_sys) disable iff (!rstN)
    !wrCtrl |=> $stable(selQ);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("Resource select changed without a control write");

  // Mismatch event only on a failed compare; set beats a same-cycle clear
  property p_event_latched;
    @(posedge clk_sys) disable iff (!rstN)
    swapIf.done |=> evtStsQ[`BMCS_EVT_DONE_BIT] &&
                    ($past(swapIf.success) || evtStsQ[`BMCS_EVT_FAIL_BIT]);
  endproperty
  a_event_latched: assert property (p_event_latched)
    else $error("Swap completion not recorded in event status");

  property p_event_sticky;
    @(posedge clk_sys) disable iff (!rstN)
    !wrSts && !swapIf.done |=> evtStsQ == $past(evtStsQ);
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("Event status changed without cause");

  property p_event_clear;
    @(posedge clk_sys) disable iff (!rstN)
    wrSts && !swapIf.done |=> (evtStsQ & $past(pwdata[`BMCS_EVT_W-1:0])) == 2'h0;
  endproperty
  a_event_clear: assert property (p_event_clear)
    else $error("Writing one did not clear event status bit");

  property p_mask_write;
    @(posedge clk_sys) disable iff (!rstN)
    wrMask |=> evtMaskQ == $past(pwdata[`BMCS_EVT_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Event mask missed a write");

  // Every transfer ends in its first access cycle
  property p_zero_wait;
    @(posedge clk_sys) disable iff (!rstN)
    setupPh |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("Access cycle not answered at once");

  // Unmapped writes leave every register alone
  property p_unmapped_quiet;
    @(posedge clk_sys) disable iff (!rstN)
    accessPh && pwrite && !addrHit |=> $stable(newValQ) && $stable(cmpValQ) &&
                                       $stable(selQ) && $stable(evtMaskQ);
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet)
    else $error("Unmapped write altered a register");

  sequence s_new_read_setup;
    setupPh && !pwrite && hitNew;
  endsequence

  sequence s_read_access;
    ##1 accessPh;
  endsequence

  sequence s_mask_read_setup;
    setupPh && !pwrite && hitMask;
  endsequence

  property p_new_value_read;
    @(posedge clk_sys) disable iff (!rstN)
    s_new_read_setup ##0 s_read_access |-> prdata == $past(newValQ);
  endproperty
  a_new_value_read: assert property (p_new_value_read)
    else $error("New value read returned wrong data");

  property p_mask_read;
    @(posedge clk_sys) disable iff (!rstN)
    s_mask_read_setup ##0 s_read_access |-> prdata == {30'h0000_0000, $past(evtMaskQ)};
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("Event mask read returned wrong data");
endmodule // bmcs_regs

/* tb/bus_mgmt_compare_swap_regs_tb_top.sv */
// Self-checking bench for the compare-swap register group behind APB
`timescale 1ns/10ps
`include "bmcs_consts.svh"
module bus_mgmt_compare_swap_regs_tb_top;
  import bmcs_pkg::*;

  logic                    clk_sys;
  logic                    reset_n;
  logic [`BMCS_ADDR_W-1:0] paddr;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  bmcs_word_t              res [4];
  bmcs_word_t              expRes [4];
  logic [31:0]             rd;
  logic                    err;
  int                      nErrors;
  int                      totalChecks;
  int                      cycles = 0;

  bmcs_regs bmcs_regs_inst (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .paddr           (paddr),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .irq             (irq),
    .busManagerId    (res[0]),
    .bandwidthAvail  (res[1]),
    .channelsAvailHi (res[2]),
    .channelsAvailLo (res[3])
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nErrors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Level output settles after the edge that launches it, so look half a cycle later
  task automatic check_irq(input logic exp);
    @(negedge clk_sys);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic check_res();
    for (int i = 0; i < 4; i++) begin
      check(res[i], expRes[i]);
    end
  endtask

  // Reset values and reserved control bits
  task automatic t_reset_values();
    apb(1'b0, `BMCS_OFF_CONTROL, 32'h0);
    check(rd, 32'h8000_0000);
    apb(1'b0, `BMCS_OFF_NEW_VALUE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `BMCS_OFF_CMP_VALUE, 32'h0);
    check(rd, 32'h0);
    check_irq(1'b0);
    check_res();
  endtask

  // Matching swap on every select code, then a chained swap
  task automatic t_swap_all();
    for (int k = 0; k < 5; k++) begin
      logic [1:0]  s;
      logic [31:0] nv;
      s  = k[1:0];
      nv = 32'hA5C3_0000 | k;
      apb(1'b1, `BMCS_OFF_NEW_VALUE, nv);
      apb(1'b1, `BMCS_OFF_CMP_VALUE, expRes[s]);
      apb(1'b1, `BMCS_OFF_CONTROL, {30'h0, s});
      expRes[s] = nv;
      apb(1'b0, `BMCS_OFF_CONTROL, 32'h0);
      check(rd, 32'h8000_0000 | s);
      check_res();
      apb(1'b0, `BMCS_OFF_IRQ_STAT, 32'h0);
      check(rd, 32'h1);
      apb(1'b1, `BMCS_OFF_IRQ_STAT, 32'h3);
    end
  endtask

  // Mismatch leaves resource alone; reserved bits written as ones read zero
  task automatic t_mismatch();
    apb(1'b1, `BMCS_OFF_NEW_VALUE, 32'hDEAD_0001);
    apb(1'b1, `BMCS_OFF_CMP_VALUE, 32'h0000_0BAD);
    apb(1'b1, `BMCS_OFF_CONTROL, 32'h7FFF_FFFE);
    apb(1'b0, `BMCS_OFF_CONTROL, 32'h0);
    check(rd, 32'h8000_0002);
    check_res();
    apb(1'b0, `BMCS_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h3);
  endtask

  // Interrupt: mask, raise, clear each bit by writing one
  task automatic t_irq();
    apb(1'b1, `BMCS_OFF_IRQ_MASK, 32'h1);
    check_irq(1'b1);
    apb(1'b1, `BMCS_OFF_IRQ_STAT, 32'h1);
    check_irq(1'b0);
    apb(1'b1, `BMCS_OFF_IRQ_MASK, 32'h3);
    check_irq(1'b1);
    apb(1'b1, `BMCS_OFF_IRQ_STAT, 32'h2);
    check_irq(1'b0);
    apb(1'b0, `BMCS_OFF_IRQ_MASK, 32'h0);
    check(rd, 32'h3);
  endtask

  // Unmapped address answers with an error and no data
  task automatic t_unmapped();
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    check_res();
  endtask

  // Reset in mid-run brings registers and resources back to their reset values
  task automatic t_mid_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    expRes = '{`BMCS_RST_BUS_MGR, `BMCS_RST_BANDWIDTH, `BMCS_RST_CHAN_HI, `BMCS_RST_CHAN_LO};
    t_reset_values();
    apb(1'b0, `BMCS_OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `BMCS_OFF_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
  endtask

  initial begin
    reset_n     = 1'b0;
    paddr       = '0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = '0;
    nErrors     = 0;
    totalChecks = 0;
    for (int i = 0; i < 4; i++) begin
      expRes[i] = 32'h0;
    end
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Internal reset copy clears two edges after release
    repeat (3) @(posedge clk_sys);
    t_reset_values();
    t_swap_all();
    t_mismatch();
    t_irq();
    t_unmapped();
    t_mid_reset();
    @(posedge clk_sys);
    end_sim();
  end
endmodule // bus_mgmt_compare_swap_regs_tb_top
